// >>> serial_flash_boot_loader.sv
`default_nettype none
`include "boot_loader_consts.svh"
module serial_flash_boot_loader #(
    parameter int unsigned WAKE_WAIT_CYCLES = `WAKE_WAIT_CYCLES,
    parameter int unsigned LOAD_WORDS = `LOAD_WORDS,
    parameter int unsigned ROM_ADDR_W = 20
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Configuration reset pin and boot straps
    input wire logic config_reset_low,
    input wire logic [1:0] boot_mode_pin,
    input wire logic [2:0] width_pin,
    input wire logic large_package_pin,
    // Flash link: io0 data out, io1 data in, io2 write-protect, io3 hold
    output logic flash_sclk,
    output logic flash_cs_low,
    output logic [3:0] flash_io_out,
    output logic [3:0] flash_io_oe_low,
    input wire logic [3:0] flash_io_in,
    // Passive link from an outside master
    input wire logic passive_clk,
    input wire logic passive_cs_low,
    input wire logic [31:0] passive_data,
    // Mask memory port
    output logic [ROM_ADDR_W-1:0] rom_addr,
    output logic rom_read,
    input wire logic [31:0] rom_data,
    // Configuration memory word stream
    output logic cfg_valid,
    input wire logic cfg_ready,
    output logic [31:0] cfg_data,
    // Status
    output logic loading,
    output logic load_done,
    output logic load_error,
    output logic user_mode_enable
);

    // ------------
    // State record
    // ------------
    typedef struct packed {
        boot_loader_pkg::load_state_t state;
        logic rst_s1;
        logic rst_s2;
        logic rst_prev;
        logic [5:0] strap_s1;
        logic [5:0] strap_s2;
        boot_loader_pkg::boot_mode_t mode;
        boot_loader_pkg::bus_width_t width;
        logic [3:0] io_s1;
        logic [3:0] io_s2;
        logic pclk_s1;
        logic pclk_s2;
        logic pclk_prev;
        logic pcs_s1;
        logic pcs_s2;
        logic [31:0] pdata_s1;
        logic [31:0] pdata_s2;
        logic [7:0] div;
        logic sclk;
        logic cs_low;
        logic [39:0] shreg;
        logic [5:0] bitcnt;
        logic [19:0] wait_cnt;
        logic [31:0] acc;
        logic [5:0] acc_bits;
        logic [23:0] words;
        logic word_valid;
        logic [31:0] word;
        logic [ROM_ADDR_W-1:0] rom_addr;
        logic rom_read;
        logic done;
        logic error;
    } regs_t;

    regs_t r;
    regs_t next_r;
    logic buf_in_ready;
    logic buf_empty;
    logic active_run;
    logic start_edge;
    logic stall;
    logic tick;
    logic rise;
    logic fall;
    logic sample;
    logic push;
    logic [31:0] din;
    logic [31:0] acc_new;
    logic [2:0] w;
    logic [5:0] nb;
    logic [6:0] fill;

    // ------------
    // Lane packing
    // ------------
    // First received lanes end up in the most significant bits
    function automatic logic [31:0] shift_in(input logic [31:0] acc,
                                             input logic [31:0] d,
                                             input logic [2:0] lanes);
        logic [31:0] res;
        res = d;
        case (lanes)
            boot_loader_pkg::W_X1: res = {acc[30:0], d[0]};
            boot_loader_pkg::W_X2: res = {acc[29:0], d[1:0]};
            boot_loader_pkg::W_X4: res = {acc[27:0], d[3:0]};
            boot_loader_pkg::W_X8: res = {acc[23:0], d[7:0]};
            boot_loader_pkg::W_X16: res = {acc[15:0], d[15:0]};
            default: res = d;
        endcase
        return res;
    endfunction

    // ------------
    // Sequencer
    // ------------
    // Reset pin, straps, flash and passive inputs pass two flops (rom_data and cfg_ready do not); only the second stage and its delayed copy are decoded
    always_comb
    begin
        next_r = r;
        tick = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        sample = 1'b0;
        push = 1'b0;
        din = 32'h0;
        acc_new = r.acc;
        w = r.width;
        nb = 6'h00;
        fill = 7'h00;
        next_r.rst_s1 = config_reset_low;
        next_r.rst_s2 = r.rst_s1;
        next_r.rst_prev = r.rst_s2;
        next_r.strap_s1 = {large_package_pin, width_pin, boot_mode_pin};
        next_r.strap_s2 = r.strap_s1;
        next_r.io_s1 = flash_io_in;
        next_r.io_s2 = r.io_s1;
        next_r.pclk_s1 = passive_clk;
        next_r.pclk_s2 = r.pclk_s1;
        next_r.pclk_prev = r.pclk_s2;
        next_r.pcs_s1 = passive_cs_low;
        next_r.pcs_s2 = r.pcs_s1;
        next_r.pdata_s1 = passive_data;
        next_r.pdata_s2 = r.pdata_s1;
        start_edge = r.rst_s2 && !r.rst_prev;
        stall = r.word_valid && !buf_in_ready;
        if (buf_in_ready)
        begin
            next_r.word_valid = 1'b0;
        end
        next_r.rom_read = 1'b0;

        // Local flash clock; frozen on a full buffer and while deselected
        if (active_run && !stall && r.state != boot_loader_pkg::ST_WAIT)
        begin
            if (r.div == 8'(`SCK_HALF_CYCLES - 1))
            begin
                next_r.div = 8'h00;
                tick = 1'b1;
                next_r.sclk = ~r.sclk;
                rise = !r.sclk;
                fall = r.sclk;
            end
            else
            begin
                next_r.div = r.div + 8'h01;
            end
        end
        else if (!active_run)
        begin
            next_r.div = 8'h00;
        end

        unique case (r.state)
            boot_loader_pkg::ST_IDLE:
            begin
                if (start_edge)
                begin
                    next_r.mode = boot_loader_pkg::boot_mode_t'(r.strap_s2[1:0]);
                    next_r.width = boot_loader_pkg::bus_width_t'(r.strap_s2[4:2]);
                    next_r.words = 24'h000000;
                    next_r.acc = 32'h0;
                    next_r.acc_bits = 6'h00;
                    next_r.done = 1'b0;
                    next_r.error = 1'b0;
                    unique case (boot_loader_pkg::boot_mode_t'(r.strap_s2[1:0]))
                        boot_loader_pkg::MODE_ACTIVE:
                        begin
                            // Active x1 on the large package, or active wider than x4
                            if (r.strap_s2[4:2] > 3'h2 ||
                                (r.strap_s2[5] && r.strap_s2[4:2] == 3'h0))
                            begin
                                next_r.state = boot_loader_pkg::ST_ERROR;
                                next_r.error = 1'b1;
                            end
                            else
                            begin
                                next_r.state = boot_loader_pkg::ST_WAKE;
                                next_r.shreg = {`CMD_RELEASE_PD, 32'h0};
                                next_r.bitcnt = `WAKE_BITS;
                                next_r.cs_low = 1'b0;
                                next_r.sclk = 1'b0;
                            end
                        end
                        boot_loader_pkg::MODE_PASSIVE:
                            next_r.state = boot_loader_pkg::ST_PASSIVE;
                        boot_loader_pkg::MODE_MASK_ROM:
                            next_r.state = boot_loader_pkg::ST_ROM;
                        boot_loader_pkg::MODE_BOUNDARY_SCAN:
                            // Scan chain configures the device; loader idles
                            next_r.state = boot_loader_pkg::ST_IDLE;
                    endcase
                end
            end
            boot_loader_pkg::ST_WAKE:
            begin
                if (rise)
                begin
                    next_r.bitcnt = r.bitcnt - 6'h01;
                end
                if (fall)
                begin
                    next_r.shreg = {r.shreg[38:0], 1'b0};
                    if (r.bitcnt == 6'h00)
                    begin
                        next_r.cs_low = 1'b1;
                        next_r.wait_cnt = 20'h00000;
                        next_r.state = boot_loader_pkg::ST_WAIT;
                    end
                end
            end
            boot_loader_pkg::ST_WAIT:
            begin
                // Flash needs this long to leave deep power-down
                if (r.wait_cnt == 20'(WAKE_WAIT_CYCLES - 1))
                begin
                    next_r.state = boot_loader_pkg::ST_READ_CMD;
                    next_r.cs_low = 1'b0;
                    next_r.bitcnt = `READ_CMD_BITS;
                    unique case (r.width)
                        boot_loader_pkg::W_X2:
                            next_r.shreg = {`CMD_READ_X2, `READ_START_ADDR,
                                            `READ_DUMMY};
                        boot_loader_pkg::W_X4:
                            next_r.shreg = {`CMD_READ_X4, `READ_START_ADDR,
                                            `READ_DUMMY};
                        default:
                            next_r.shreg = {`CMD_READ_X1, `READ_START_ADDR,
                                            `READ_DUMMY};
                    endcase
                end
                else
                begin
                    next_r.wait_cnt = r.wait_cnt + 20'h00001;
                end
            end
            boot_loader_pkg::ST_READ_CMD:
            begin
                if (rise)
                begin
                    next_r.bitcnt = r.bitcnt - 6'h01;
                end
                if (fall)
                begin
                    next_r.shreg = {r.shreg[38:0], 1'b0};
                    if (r.bitcnt == 6'h00)
                    begin
                        next_r.state = boot_loader_pkg::ST_STREAM;
                    end
                end
            end
            boot_loader_pkg::ST_STREAM:
            begin
                // Flash launches on the falling edge; catch on the rising one
                sample = rise;
                din = (r.width == boot_loader_pkg::W_X1) ?
                      {31'h0, r.io_s2[1]} : {28'h0, r.io_s2};
            end
            boot_loader_pkg::ST_PASSIVE:
            begin
                // Outside clock is sampled; it cannot be stalled
                sample = r.pclk_s2 && !r.pclk_prev && !r.pcs_s2;
                din = r.pdata_s2;
            end
            boot_loader_pkg::ST_ROM:
            begin
                if (r.rom_read)
                begin
                    acc_new = rom_data;
                    push = 1'b1;
                end
                else if (!r.word_valid)
                begin
                    next_r.rom_read = 1'b1;
                    next_r.rom_addr = ROM_ADDR_W'(r.words);
                end
            end
            boot_loader_pkg::ST_DONE:
            begin
                next_r.cs_low = 1'b1;
            end
            boot_loader_pkg::ST_ERROR:
            begin
                next_r.cs_low = 1'b1;
                next_r.error = 1'b1;
            end
            default:
                next_r.state = boot_loader_pkg::ST_ERROR;
        endcase

        // Gather lanes into 32-bit words
        if (sample)
        begin
            nb = 6'h01 << w;
            acc_new = shift_in(r.acc, din, w);
            fill = {1'b0, r.acc_bits} + {1'b0, nb};
            if (fill == 7'h20)
            begin
                push = 1'b1;
                next_r.acc = 32'h0;
                next_r.acc_bits = 6'h00;
            end
            else
            begin
                next_r.acc = acc_new;
                next_r.acc_bits = fill[5:0];
            end
        end

        // Hand a word over; a passive word meeting a full buffer is lost
        if (push)
        begin
            if (stall)
            begin
                next_r.state = boot_loader_pkg::ST_ERROR;
                next_r.error = 1'b1;
            end
            else
            begin
                next_r.word = acc_new;
                next_r.word_valid = 1'b1;
                next_r.words = r.words + 24'h000001;
                if (r.words == 24'(LOAD_WORDS - 1))
                begin
                    next_r.state = boot_loader_pkg::ST_DONE;
                    next_r.done = 1'b1;
                    next_r.cs_low = 1'b1;
                    next_r.sclk = 1'b0;
                end
            end
        end

        // Holding the pin low aborts and rearms the loader
        if (!r.rst_s2)
        begin
            next_r.state = boot_loader_pkg::ST_IDLE;
            next_r.cs_low = 1'b1;
            next_r.sclk = 1'b0;
            next_r.done = 1'b0;
            next_r.error = 1'b0;
            next_r.word_valid = 1'b0;
            next_r.rom_read = 1'b0;
        end
    end

    // Register the record
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r <= '0;
            r.state <= boot_loader_pkg::ST_IDLE;
            r.cs_low <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ------------
    // Stream buffer
    // ------------
    word_buffer #(
        .WIDTH(32),
        .DEPTH(2)
    ) u_word_buffer (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_valid(r.word_valid),
        .in_ready(buf_in_ready),
        .in_data(r.word),
        .out_valid(cfg_valid),
        .out_ready(cfg_ready),
        .out_data(cfg_data),
        .empty(buf_empty)
    );

    // ------------
    // Pins and status
    // ------------
    assign active_run = (r.state == boot_loader_pkg::ST_WAKE) ||
                        (r.state == boot_loader_pkg::ST_WAIT) ||
                        (r.state == boot_loader_pkg::ST_READ_CMD) ||
                        (r.state == boot_loader_pkg::ST_STREAM);
    assign flash_sclk = r.sclk;
    assign flash_cs_low = r.cs_low;
    // Protect and hold sit high so reads are never paused
    assign flash_io_out = {2'b11, 1'b0, r.shreg[39]};
    // io0 is released for dual and quad data; io2/io3 only for quad
    assign flash_io_oe_low[0] = !(active_run &&
        !(r.state == boot_loader_pkg::ST_STREAM &&
          r.width != boot_loader_pkg::W_X1));
    assign flash_io_oe_low[1] = 1'b1;
    assign flash_io_oe_low[2] = !(active_run &&
        !(r.state == boot_loader_pkg::ST_STREAM &&
          r.width == boot_loader_pkg::W_X4));
    assign flash_io_oe_low[3] = flash_io_oe_low[2];
    assign rom_addr = r.rom_addr;
    assign rom_read = r.rom_read;
    assign loading = !(r.state == boot_loader_pkg::ST_IDLE ||
                       r.state == boot_loader_pkg::ST_DONE ||
                       r.state == boot_loader_pkg::ST_ERROR);
    assign load_done = r.done;
    assign load_error = r.error;
    // User logic waits until the last word has left the buffer
    assign user_mode_enable = r.done && buf_empty && !r.word_valid;

endmodule
`default_nettype wire

// >>> boot_loader_consts.svh
`ifndef BOOT_LOADER_CONSTS_SVH
`define BOOT_LOADER_CONSTS_SVH

// ------------
// Clock and link timing
// ------------
`define CLK_SYS_MHZ 250
`define FLASH_SCK_MAX_MHZ 20
// Half period rounded up, so the flash clock never exceeds its limit
`define SCK_HALF_CYCLES \
    ((`CLK_SYS_MHZ + 2 * `FLASH_SCK_MAX_MHZ - 1) / (2 * `FLASH_SCK_MAX_MHZ))
`define WAKE_WAIT_US 30
`define WAKE_WAIT_CYCLES (`WAKE_WAIT_US * `CLK_SYS_MHZ)

// ------------
// Flash instructions and layout
// ------------
`define CMD_RELEASE_PD 8'hAB
`define CMD_READ_X1 8'h0B
`define CMD_READ_X2 8'h3B
`define CMD_READ_X4 8'h6B
`define READ_START_ADDR 24'h000000
`define READ_DUMMY 8'h00
`define WAKE_BITS 6'h08
`define READ_CMD_BITS 6'h28
`define FLASH_MBITS 16
`define LOAD_WORDS (`FLASH_MBITS * 1024 * 1024 / 32)

`endif

// >>> boot_loader_pkg.sv
`default_nettype none
package boot_loader_pkg;

    // ------------
    // Boot source strap
    // ------------
    typedef enum logic [1:0] {
        MODE_ACTIVE = 2'h0,
        MODE_PASSIVE = 2'h1,
        MODE_MASK_ROM = 2'h2,
        MODE_BOUNDARY_SCAN = 2'h3
    } boot_mode_t;

    // Data width as log2 of the lane count; 6 and 7 are illegal
    typedef enum logic [2:0] {
        W_X1 = 3'h0,
        W_X2 = 3'h1,
        W_X4 = 3'h2,
        W_X8 = 3'h3,
        W_X16 = 3'h4,
        W_X32 = 3'h5
    } bus_width_t;

    // ------------
    // Loader sequence
    // ------------
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_WAKE = 9'h002,
        ST_WAIT = 9'h004,
        ST_READ_CMD = 9'h008,
        ST_STREAM = 9'h010,
        ST_PASSIVE = 9'h020,
        ST_ROM = 9'h040,
        ST_DONE = 9'h080,
        ST_ERROR = 9'h100
    } load_state_t;

endpackage
`default_nettype wire

// >>> word_buffer.sv
`default_nettype none
module word_buffer #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic empty
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ------------
    // State record
    // ------------
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } buf_regs_t;

    buf_regs_t r;
    buf_regs_t next_r;
    logic do_wr;
    logic do_rd;

    // Full and empty come straight from the count, never guessed
    assign in_ready = (r.count != (AW + 1)'(DEPTH));
    assign out_valid = (r.count != '0);
    assign empty = ~out_valid;
    assign out_data = r.mem[r.rd];

    // Pointers wrap explicitly so a depth that is not a power of two works
    always_comb
    begin
        next_r = r;
        do_wr = in_valid && in_ready;
        do_rd = out_valid && out_ready;
        if (do_wr)
        begin
            next_r.mem[r.wr] = in_data;
            next_r.wr = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + 1'b1;
        end
        if (do_rd)
        begin
            next_r.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + 1'b1;
        end
        if (do_wr && !do_rd)
        begin
            next_r.count = r.count + 1'b1;
        end
        else if (do_rd && !do_wr)
        begin
            next_r.count = r.count - 1'b1;
        end
    end

    // Register the record
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

endmodule
`default_nettype wire

// >>> serial_flash_boot_loader_properties.sv
`default_nettype none
module serial_flash_boot_loader_properties #(
    parameter int unsigned WAKE_WAIT_CYCLES = 7500
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Pin and flash link
    input wire logic config_reset_low,
    input wire logic flash_sclk,
    input wire logic flash_cs_low,
    input wire logic [3:0] flash_io_out,
    input wire logic [3:0] flash_io_oe_low,
    // Stream and status
    input wire logic cfg_valid,
    input wire logic cfg_ready,
    input wire logic [31:0] cfg_data,
    input wire logic loading,
    input wire logic load_done,
    input wire logic load_error,
    input wire logic user_mode_enable
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    int hi;

    // Select-high cycles inside a load
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            hi <= 0;
        else
            hi <= (flash_cs_low && loading) ? hi + 1 : 0;
    end

    // ------------
    // Flash link and status
    // ------------
    a_idle_deselect: assert property (!loading [*2] |-> flash_cs_low)
        else $error("select low outside a load");
    a_sclk_idle: assert property (flash_cs_low |-> !flash_sclk)
        else $error("flash clock runs while deselected");
    a_sclk_high: assert property ($rose(flash_sclk) |-> flash_sclk [*7])
        else $error("flash clock high phase too short");
    a_wp_hold: assert property (!flash_cs_low |-> flash_io_out[3:2] == 2'h3)
        else $error("protect or hold driven low");
    a_cmd_drive: assert property ($fell(flash_cs_low) |->
        flash_io_oe_low[0] == 1'b0 && flash_io_oe_low[3:2] == 2'h0)
        else $error("command lane not driven");
    a_wake_gap: assert property ($fell(flash_cs_low) && hi > 1 |->
        hi >= WAKE_WAIT_CYCLES) else $error("wake wait too short");
    a_user_gate: assert property (user_mode_enable |->
        load_done && !cfg_valid) else $error("user mode before load end");
    a_refuse_quiet: assert property (load_error |->
        flash_cs_low && !loading) else $error("activity after refusal");
    a_start_pin: assert property ($rose(loading) |-> config_reset_low)
        else $error("load started with pin low");
    a_stream_hold: assert property (cfg_valid && !cfg_ready |=>
        cfg_valid && $stable(cfg_data)) else $error("stalled word lost");
endmodule

bind serial_flash_boot_loader serial_flash_boot_loader_properties #(
    .WAKE_WAIT_CYCLES(WAKE_WAIT_CYCLES)
) serial_flash_boot_loader_properties_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .config_reset_low(config_reset_low), .flash_sclk(flash_sclk),
    .flash_cs_low(flash_cs_low), .flash_io_out(flash_io_out),
    .flash_io_oe_low(flash_io_oe_low), .cfg_valid(cfg_valid),
    .cfg_ready(cfg_ready), .cfg_data(cfg_data), .loading(loading),
    .load_done(load_done), .load_error(load_error),
    .user_mode_enable(user_mode_enable)
);
`default_nettype wire

// >>> boot_flash_model.sv
`default_nettype none
module boot_flash_model (
    // Link from the loader
    input wire logic clk_sys,
    input wire logic flash_sclk,
    input wire logic flash_cs_low,
    input wire logic [3:0] flash_io_out,
    // Data back and observations
    output logic [3:0] flash_io_in,
    output logic [7:0] wake_op,
    output logic [39:0] read_op,
    output int gap,
    output int trans
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] PAT = 32'hC3A5_0F96;
    logic [39:0] shreg = 40'h0;
    int rises = 0;
    int hi = 0;
    int k = 0;

    // ------------
    // Behaviour of the serial flash
    // ------------
    initial
    begin
        flash_io_in = 4'h0;
        trans = 0;
        gap = 0;
    end
    // Deselected cycles
    always @(posedge clk_sys)
        hi <= flash_cs_low ? hi + 1 : 0;
    // New transaction
    always @(negedge flash_cs_low)
    begin
        gap = hi;
        rises = 0;
        k = 0;
        trans = trans + 1;
    end
    // Released lines show the inverse level
    always @(posedge flash_cs_low)
    begin
        if (rises == 8)
            wake_op = shreg[7:0];
        flash_io_in = ~flash_io_in;
    end
    // Instruction bits on rising edges
    always @(posedge flash_sclk)
    begin
        if (!flash_cs_low)
        begin
            shreg = {shreg[38:0], flash_io_out[0]};
            rises = rises + 1;
            if (rises == 40)
                read_op = shreg;
        end
    end
    // Data leaves on falling edges after the header
    always @(negedge flash_sclk)
    begin
        if (!flash_cs_low && rises >= 40)
        begin
            flash_io_in = {4{PAT[31 - k % 32] ^ k[5]}};
            k = k + 1;
        end
    end
endmodule
`default_nettype wire

// >>> test_serial_flash_boot_loader.sv
`default_nettype none
module test_serial_flash_boot_loader;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] PAT = 32'hC3A5_0F96;
    logic clk_sys = 0, sys_rst = 1, config_reset_low = 0, large_pin = 0;
    logic [1:0] mode_pin = 2'h0;
    logic [2:0] width_pin = 3'h0;
    logic flash_sclk, flash_cs_low, passive_clk = 0, passive_cs_low = 1;
    logic [3:0] io_out, io_oe_low, io_in;
    logic [31:0] passive_data = 32'h0, rom_data, cfg_data;
    logic [19:0] rom_addr;
    logic rom_read, cfg_valid, cfg_ready = 0, loading, done, err, user;
    logic [7:0] wake_op;
    logic [39:0] read_op;
    logic [31:0] got[$];
    int gap, trans, tr0, n, i, bad_count = 0, num_checks = 0, cyc = 0;

    serial_flash_boot_loader #(.WAKE_WAIT_CYCLES(20), .LOAD_WORDS(4))
    serial_flash_boot_loader_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .config_reset_low(config_reset_low), .boot_mode_pin(mode_pin),
        .width_pin(width_pin), .large_package_pin(large_pin),
        .flash_sclk(flash_sclk), .flash_cs_low(flash_cs_low),
        .flash_io_out(io_out), .flash_io_oe_low(io_oe_low),
        .flash_io_in(io_in), .passive_clk(passive_clk),
        .passive_cs_low(passive_cs_low), .passive_data(passive_data),
        .rom_addr(rom_addr), .rom_read(rom_read), .rom_data(rom_data),
        .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_data(cfg_data),
        .loading(loading), .load_done(done), .load_error(err),
        .user_mode_enable(user));
    boot_flash_model boot_flash_model_inst (.clk_sys(clk_sys),
        .flash_sclk(flash_sclk), .flash_cs_low(flash_cs_low),
        .flash_io_out(io_out), .flash_io_in(io_in), .wake_op(wake_op),
        .read_op(read_op), .gap(gap), .trans(trans));

    // Mask memory answers combinationally, in the same cycle as the pulse
    assign rom_data = {12'hA5C, rom_addr};
    // Sink takes one cycle in four
    always @(posedge clk_sys)
    begin
        if (cfg_valid === 1'b1 && cfg_ready === 1'b1)
            got.push_back(cfg_data);
        cyc <= cyc + 1;
        cfg_ready <= (cyc[1:0] == 2'h0);
    end
    initial
    begin
        forever #2 clk_sys = ~clk_sys;
    end

    // ------------
    // Shared tasks
    // ------------
    task chk(input logic [63:0] a, input logic [63:0] e);
        num_checks++;
        if (a !== e)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask
    task start(input logic [1:0] m, input logic [2:0] w, input logic lg);
        @(posedge clk_sys);
        got.delete();
        tr0 = trans;
        config_reset_low <= 1'b0;
        mode_pin <= m;
        width_pin <= w;
        large_pin <= lg;
        repeat (6) @(posedge clk_sys);
        config_reset_low <= 1'b1;
    endtask
    task wait_end;
        for (n = 0; n < 4000 && user !== 1'b1 && err !== 1'b1; n++)
            @(posedge clk_sys);
        #1;
    endtask
    task stop_test;
        $display("checks=%0d errors=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------
    // Scenarios
    // ------------
    task run_active_x1;
        start(2'h0, 3'h0, 1'b0);
        wait_end;
        chk(wake_op, 8'hAB);
        chk(read_op, {8'h0B, 32'h0});
        chk(gap >= 20, 1);
        chk(trans - tr0, 2);
        chk(got.size(), 4);
        for (i = 0; i < 4; i++)
            chk(got[i], PAT ^ {32{i[0]}});
        chk({user, flash_cs_low, flash_sclk}, 3'h6);
    endtask
    task run_active_wide(input logic [2:0] w, input logic [7:0] op);
        start(2'h0, w, 1'b1);
        wait_end;
        chk(read_op[39:32], op);
        chk({err, done, got.size()}, {2'h1, 32'h4});
    endtask
    task run_refused(input logic [1:0] m, input logic [2:0] w,
        input logic lg, input logic exp_err);
        start(m, w, lg);
        wait_end;
        chk({err, loading, trans - tr0}, {exp_err, 33'h0});
    endtask
    task run_rom;
        start(2'h2, 3'h0, 1'b0);
        wait_end;
        chk({user, trans - tr0, got.size()}, {1'b1, 64'h4});
        for (i = 0; i < 4; i++)
            chk(got[i], {12'hA5C, i[19:0]});
    endtask
    task run_passive;
        start(2'h1, 3'h5, 1'b0);
        repeat (10) @(posedge clk_sys);
        passive_cs_low <= 1'b0;
        for (i = 0; i < 4; i++)
        begin
            passive_data <= 32'h5A00_0010 + i;
            repeat (8) @(posedge clk_sys);
            passive_clk <= 1'b1;
            repeat (8) @(posedge clk_sys);
            passive_clk <= 1'b0;
        end
        passive_cs_low <= 1'b1;
        wait_end;
        chk({user, got.size()}, {1'b1, 32'h4});
        for (i = 0; i < 4; i++)
            chk(got[i], 32'h5A00_0010 + i);
    endtask

    initial
    begin
        #200000;
        bad_count++;
        stop_test;
    end
    initial
    begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        run_active_x1;
        run_active_wide(3'h1, 8'h3B);
        run_active_wide(3'h2, 8'h6B);
        run_refused(2'h0, 3'h0, 1'b1, 1'b1);
        run_refused(2'h0, 3'h3, 1'b0, 1'b1);
        run_refused(2'h3, 3'h0, 1'b0, 1'b0);
        run_rom;
        run_passive;
        stop_test;
    end
endmodule
`default_nettype wire
